// File: hdl/lsc_ch34_msg.sv
// lsc_ch34_msg: channel 3/4 set-point message decoder and responder
//
// Behaviour
// (R1) A write frame has parity in bit 15, the identifier in 14..10 and the payload in 9..0.
// (R2) Identifier 01100 addresses channel three and 01101 channel four.
// (R3) One regulation-disable bit selects current regulation or plain PWM for both channels.
// (R4) With regulation on, all ten payload bits become the channel current target.
// (R5) With regulation off, payload bits 9..2 are the duty cycle and bits 1..0 are ignored.
// (R6) Response bit 14 is one when the previous frame had bad parity, zero when it was valid.
// (R7) Response bit 13 reports an overcurrent shutdown of the channel.
// (R8) Response bit 12 reports an open load on the channel.
// (R9) Response bit 11 reports an overtemperature shutdown of the channel.
// (R10) Response bit 10 reports drain-source detection and causes no shutdown.
// (R11) Regulation on, feedback select clear: the payload echoes the stored current target.
// (R12) Regulation on, feedback select set: the payload is the regulator output duty.
// (R13) Regulation off, feedback select clear: the payload is the duty with bits 1..0 zero.
// (R14) Regulation off, feedback select set: the payload is the channel ADC current.
// (R15) Both ends use one parity over all 16 bits, odd unless the parameter says otherwise.
// (R16) The answer to a frame is shifted out during the following transfer.
`include "lsc_cfg.svh"
module lsc_ch34_msg #(
  parameter logic PARITY_ODD = `LSC_PARITY_ODD
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  // serial pins
  input  wire logic               spi_sclk,
  input  wire logic               spi_cs_b,
  input  wire logic               spi_mosi,
  output logic                    spi_miso,
  output logic                    spi_miso_oe_b,
  // channel state from driver logic
  input  wire lsc_pkg::lsc_flags_t ch3_flags,
  input  wire lsc_pkg::lsc_flags_t ch4_flags,
  input  wire logic [7:0]         ch3_regulator_duty,
  input  wire logic [7:0]         ch4_regulator_duty,
  input  wire logic [9:0]         ch3_adc_current,
  input  wire logic [9:0]         ch4_adc_current,
  // channel settings to driver logic
  output logic                    regulation_disable_ch34,
  output logic                    regulation_feedback_select,
  output logic [9:0]              ch3_current_target,
  output logic [9:0]              ch4_current_target,
  output logic [7:0]              ch3_pwm_duty,
  output logic [7:0]              ch4_pwm_duty,
  // AXI4-Lite slave
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // interrupt
  output logic                    irq
);
  import lsc_pkg::*;

  // ****************************************************************
  // serial front end
  // ****************************************************************
  logic [2:0]              pin_q;
  logic [15:0]             rx_word;
  logic                    rx_len_ok;
  logic                    rx_done;
  lsc_resp_t               resp_word;
  lsc_cmd_t                cmd;
  logic                    frame_ok;

  lsc_sync3 #(.W(3), .RST_VAL(`LSC_SYNC_RST)) u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d       ({spi_mosi, spi_cs_b, spi_sclk}),
    .q       (pin_q)
  );

  lsc_spi_shift #(.FRAME_BITS(`LSC_FRAME_BITS)) u_shift (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .sclk      (pin_q[0]),
    .cs_b      (pin_q[1]),
    .mosi      (pin_q[2]),
    .miso      (spi_miso),
    .miso_oe_b (spi_miso_oe_b),
    .tx_word   (resp_word),          // (R16)
    .rx_word   (rx_word),
    .rx_len_ok (rx_len_ok),
    .rx_done   (rx_done)
  );

  // field split of the received frame
  assign cmd      = lsc_cmd_t'(rx_word);                     // (R1)
  // a short or long frame counts as a parity failure too
  assign frame_ok = rx_len_ok && ((^rx_word) == PARITY_ODD); // (R15)

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [1:0]              ctrl;
  logic [`LSC_IRQ_W-1:0]   irq_status;
  logic [`LSC_IRQ_W-1:0]   irq_enable;
  logic [`LSC_IRQ_W-1:0]   irq_set;
  logic [`LSC_IRQ_W-1:0]   irq_clr;
  logic [15:0]             last_frame;
  logic                    last_perr;

  // single mode bit governs both channels
  assign regulation_disable_ch34    = ctrl[`LSC_CTRL_DIS]; // (R3)
  assign regulation_feedback_select = ctrl[`LSC_CTRL_FB];

  // ****************************************************************
  // message decode and channel storage
  // ****************************************************************
  lsc_chan_t               chan;
  lsc_chan_t               resp_ch;
  logic                    resp_pend;

  // identifier decode, only for frames that passed the checks
  always_comb begin
    chan = LSC_CH_NONE;
    if (frame_ok && cmd.message_identifier == `LSC_ID_CH3) begin
      chan = LSC_CH_THREE;                                   // (R2)
    end else if (frame_ok && cmd.message_identifier == `LSC_ID_CH4) begin
      chan = LSC_CH_FOUR;                                    // (R2)
    end
  end

  // set points: current target or duty, depending on the mode bit
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ch3_current_target <= '0;
      ch4_current_target <= '0;
      ch3_pwm_duty       <= '0;
      ch4_pwm_duty       <= '0;
    end else if (rx_done) begin
      if (chan == LSC_CH_THREE && !regulation_disable_ch34) begin
        ch3_current_target <= cmd.payload;                   // (R4)
      end
      if (chan == LSC_CH_FOUR && !regulation_disable_ch34) begin
        ch4_current_target <= cmd.payload;                   // (R4)
      end
      // low two bits carry no duty information
      if (chan == LSC_CH_THREE && regulation_disable_ch34) begin
        ch3_pwm_duty <= cmd.payload[9:2];                    // (R5)
      end
      if (chan == LSC_CH_FOUR && regulation_disable_ch34) begin
        ch4_pwm_duty <= cmd.payload[9:2];                    // (R5)
      end
    end
  end

  // frame bookkeeping; response is built one cycle after storage so
  // that the echo already shows the value just written
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      resp_pend  <= 1'b0;
      resp_ch    <= LSC_CH_NONE;
      last_perr  <= 1'b0;
      last_frame <= '0;
    end else begin
      resp_pend <= rx_done;
      if (rx_done) begin
        resp_ch    <= chan;
        last_perr  <= !frame_ok;                             // (R6)
        last_frame <= rx_word;
      end
    end
  end

  // ****************************************************************
  // response frame
  // ****************************************************************
  lsc_resp_t               next_resp;
  lsc_flags_t              sel_flags;
  logic [9:0]              sel_target;
  logic [7:0]              sel_duty;
  logic [7:0]              sel_reg_duty;
  logic [9:0]              sel_adc;

  // pick the addressed channel; an unknown message reports nothing
  always_comb begin
    sel_flags    = '0;
    sel_target   = '0;
    sel_duty     = '0;
    sel_reg_duty = '0;
    sel_adc      = '0;
    if (resp_ch == LSC_CH_THREE) begin
      sel_flags    = ch3_flags;
      sel_target   = ch3_current_target;
      sel_duty     = ch3_pwm_duty;
      sel_reg_duty = ch3_regulator_duty;
      sel_adc      = ch3_adc_current;
    end else if (resp_ch == LSC_CH_FOUR) begin
      sel_flags    = ch4_flags;
      sel_target   = ch4_current_target;
      sel_duty     = ch4_pwm_duty;
      sel_reg_duty = ch4_regulator_duty;
      sel_adc      = ch4_adc_current;
    end
  end

  // payload by mode and feedback select, then the parity bit
  always_comb begin
    next_resp = '0;
    next_resp.frame_parity_error_flag = last_perr;           // (R6)
    // flags pass straight through; vds is report only      // (R7) (R8)
    next_resp.flags = sel_flags;                             // (R9) (R10)
    unique case ({regulation_disable_ch34, regulation_feedback_select})
      2'h0: next_resp.payload = sel_target;                  // (R11)
      2'h1: next_resp.payload = {sel_reg_duty, 2'h0};        // (R12)
      2'h2: next_resp.payload = {sel_duty, 2'h0};            // (R13)
      2'h3: next_resp.payload = sel_adc;                     // (R14)
    endcase
    next_resp.parity = PARITY_ODD ^ (^next_resp[14:0]);      // (R15)
  end

  // held until the next select loads it into the shifter
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      resp_word <= '0;
    end else if (resp_pend) begin
      resp_word <= next_resp;                                // (R16)
    end
  end

  // ****************************************************************
  // interrupt events
  // ****************************************************************
  logic                    fault_q;
  logic                    fault_now;

  // overcurrent, open-load and overtemperature faults; drain-source detect is not an alarm
  assign fault_now =
    ch3_flags.overcurrent_shutdown_flag | ch3_flags.open_load_flag |
    ch3_flags.overtemp_shutdown_flag | ch4_flags.overcurrent_shutdown_flag |
    ch4_flags.open_load_flag | ch4_flags.overtemp_shutdown_flag;

  always_comb begin
    irq_set = '0;
    irq_set[`LSC_IRQ_FRAME] = rx_done && frame_ok;
    irq_set[`LSC_IRQ_PERR]  = rx_done && !frame_ok;
    irq_set[`LSC_IRQ_FAULT] = fault_now && !fault_q;
  end

  // sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fault_q    <= 1'b0;
      irq_status <= `LSC_IRQ_RST;
    end else begin
      fault_q    <= fault_now;
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_status & irq_enable);

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic                    aw_held;
  logic                    w_held;
  logic [5:0]              aw_idx;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    wr_fire;
  logic [31:0]             rd_mux;
  logic [1:0]              rd_resp;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  // address and data may arrive in either order
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_idx       <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LSC_AXI_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_idx > `LSC_IDX_FRAME) ? `LSC_AXI_SLVERR
                                                  : `LSC_AXI_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // writable fields sit in byte lane 0
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl       <= `LSC_CTRL_RST;
      irq_enable <= `LSC_IRQ_RST;
    end else if (wr_fire && w_strb[0]) begin
      if (aw_idx == `LSC_IDX_CTRL)   ctrl       <= w_data[1:0];
      if (aw_idx == `LSC_IDX_ENABLE) irq_enable <= w_data[2:0];
    end
  end

  assign irq_clr = (wr_fire && w_strb[0] && aw_idx == `LSC_IDX_CLEAR)
                   ? w_data[2:0] : '0;

  // read decode; the clear register reads as zero
  always_comb begin
    rd_mux  = '0;
    rd_resp = `LSC_AXI_OKAY;
    unique case (s_axi_araddr[7:2])
      `LSC_IDX_CTRL:   rd_mux = {30'h0, ctrl};
      `LSC_IDX_CH3:    rd_mux = {8'h0, ch3_pwm_duty, 6'h0, ch3_current_target};
      `LSC_IDX_CH4:    rd_mux = {8'h0, ch4_pwm_duty, 6'h0, ch4_current_target};
      `LSC_IDX_STATUS: rd_mux = {29'h0, irq_status};
      `LSC_IDX_CLEAR:  rd_mux = '0;
      `LSC_IDX_ENABLE: rd_mux = {29'h0, irq_enable};
      `LSC_IDX_FRAME:  rd_mux = {15'h0, last_perr, last_frame};
      default:         rd_resp = `LSC_AXI_SLVERR;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `LSC_AXI_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_resp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_ch3_target_store: assert property ( // (R4)
    rx_done && chan == LSC_CH_THREE && !regulation_disable_ch34
    |=> ch3_current_target == $past(rx_word[9:0]))
    else $error("ch3 target not taken from payload");

  chk_ch4_id_decode: assert property ( // (R2)
    rx_done && frame_ok && rx_word[14:10] == 5'h0d
    && !regulation_disable_ch34
    |=> ch4_current_target == $past(rx_word[9:0])
        && $stable(ch3_current_target))
    else $error("ch4 message not routed to ch4");

  chk_duty_store: assert property ( // (R5)
    rx_done && chan == LSC_CH_THREE && regulation_disable_ch34
    |=> ch3_pwm_duty == $past(rx_word[9:2])
        && $stable(ch3_current_target))
    else $error("ch3 duty not taken from bits 9..2");

  chk_perr_reply: assert property ( // (R6)
    rx_done |-> ##2 resp_word.frame_parity_error_flag
                    == $past(!frame_ok, 2))
    else $error("parity error flag wrong in reply");

  chk_reply_parity: assert property ( // (R15)
    resp_pend |=> (^resp_word) == PARITY_ODD)
    else $error("reply parity sense wrong");

  chk_flag_echo: assert property ( // (R7)
    resp_pend && resp_ch == LSC_CH_FOUR
    |=> resp_word.flags == $past(ch4_flags))
    else $error("ch4 fault flags not echoed");

  chk_pwm_low_zero: assert property ( // (R13)
    resp_pend && regulation_disable_ch34 && !regulation_feedback_select
    |=> resp_word.payload[1:0] == 2'h0
        && resp_word.payload[9:2] == $past(sel_duty))
    else $error("pwm duty readback malformed");

  chk_adc_readback: assert property ( // (R14)
    resp_pend && regulation_disable_ch34 && regulation_feedback_select
    |=> resp_word.payload == $past(sel_adc))
    else $error("adc readback missing");

  chk_resp_hold: assert property ( // (R16)
    !resp_pend |=> $stable(resp_word))
    else $error("reply changed outside frame end");

  chk_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule // lsc_ch34_msg

// File: hdl/lsc_cfg.svh
// lsc_cfg.svh: offsets, field positions and reset values of the block
`ifndef LSC_CFG_SVH
`define LSC_CFG_SVH
// ****************************************************************
// serial frame layout
// ****************************************************************
`define LSC_FRAME_BITS   16
`define LSC_CNT_W        5
`define LSC_ID_CH3       5'h0c
`define LSC_ID_CH4       5'h0d
`define LSC_PARITY_ODD   1'b1
`define LSC_SYNC_RST     3'h2
// ****************************************************************
// register word indices, byte address is four times the index
// ****************************************************************
`define LSC_IDX_CTRL     6'h00
`define LSC_IDX_CH3      6'h01
`define LSC_IDX_CH4      6'h02
`define LSC_IDX_STATUS   6'h03
`define LSC_IDX_CLEAR    6'h04
`define LSC_IDX_ENABLE   6'h05
`define LSC_IDX_FRAME    6'h06
// ****************************************************************
// field positions and reset values
// ****************************************************************
`define LSC_CTRL_DIS     0
`define LSC_CTRL_FB      1
`define LSC_CTRL_RST     2'h0
`define LSC_IRQ_FRAME    0
`define LSC_IRQ_PERR     1
`define LSC_IRQ_FAULT    2
`define LSC_IRQ_W        3
`define LSC_IRQ_RST      3'h0
`define LSC_AXI_OKAY     2'h0
`define LSC_AXI_SLVERR   2'h2
`endif

// File: hdl/lsc_pkg.sv
// lsc_pkg: types shared by the ch3/ch4 message block
package lsc_pkg;
  // fault flags of one low-side channel, in response bit order 13..10
  typedef struct packed {
    logic overcurrent_shutdown_flag;
    logic open_load_flag;
    logic overtemp_shutdown_flag;
    logic drain_source_detect_flag;
  } lsc_flags_t;
  // response frame as shifted out
  typedef struct packed {
    logic       parity;
    logic       frame_parity_error_flag;
    lsc_flags_t flags;
    logic [9:0] payload;
  } lsc_resp_t;
  // write frame as received
  typedef struct packed {
    logic       parity;
    logic [4:0] message_identifier;
    logic [9:0] payload;
  } lsc_cmd_t;
  typedef enum logic [1:0] {
    LSC_SPI_IDLE  = 2'h0,
    LSC_SPI_SHIFT = 2'h1,
    LSC_SPI_DONE  = 2'h3
  } lsc_spi_state_t;
  typedef enum logic [1:0] {
    LSC_CH_NONE  = 2'h0,
    LSC_CH_THREE = 2'h1,
    LSC_CH_FOUR  = 2'h2
  } lsc_chan_t;
endpackage

// File: hdl/lsc_sync3.sv
// lsc_sync3: three-stage pin synchroniser with agreement filter
`include "lsc_cfg.svh"
module lsc_sync3 #(
  parameter int         W       = 3,
  parameter logic [2:0] RST_VAL = `LSC_SYNC_RST
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // pins in, filtered levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // s1 feeds s2 only; a change counts once s2 and s3 agree
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= W'(RST_VAL);
      s2 <= W'(RST_VAL);
      s3 <= W'(RST_VAL);
      q  <= W'(RST_VAL);
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) q[i] <= s3[i];
      end
    end
  end
endmodule // lsc_sync3

// File: hdl/lsc_spi_shift.sv
// lsc_spi_shift: 16-bit full-duplex serial shifter, mode 0
`include "lsc_cfg.svh"
module lsc_spi_shift #(
  parameter int FRAME_BITS = `LSC_FRAME_BITS
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  // synchronised pin levels
  input  wire logic                  sclk,
  input  wire logic                  cs_b,
  input  wire logic                  mosi,
  // serial out
  output logic                       miso,
  output logic                       miso_oe_b,
  // frame side
  input  wire logic [FRAME_BITS-1:0] tx_word,
  output logic      [FRAME_BITS-1:0] rx_word,
  output logic                       rx_len_ok,
  output logic                       rx_done
);
  import lsc_pkg::*;
  lsc_spi_state_t              state;
  logic                        sclk_q;
  logic [`LSC_CNT_W-1:0]       cnt;
  logic [FRAME_BITS-1:0]       tx_sr;

  // frame sequencing: select opens, edges shift, deselect closes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state  <= LSC_SPI_IDLE;
      sclk_q <= 1'b0;
      cnt    <= '0;
      tx_sr  <= '0;
      rx_word <= '0;
    end else begin
      sclk_q <= sclk;
      unique case (state)
        LSC_SPI_IDLE: begin
          if (!cs_b) begin
            state <= LSC_SPI_SHIFT;
            cnt   <= '0;
            tx_sr <= tx_word;
          end
        end
        LSC_SPI_SHIFT: begin
          if (cs_b) begin
            state <= LSC_SPI_DONE;
          end else if (sclk && !sclk_q) begin
            rx_word <= {rx_word[FRAME_BITS-2:0], mosi};
            // saturate so an overlong frame never wraps back to 16
            if (cnt != '1) cnt <= cnt + 1'b1;
          end else if (!sclk && sclk_q) begin
            tx_sr <= {tx_sr[FRAME_BITS-2:0], 1'b0};
          end
        end
        LSC_SPI_DONE: state <= LSC_SPI_IDLE;
        // the unused code falls back to idle
        default:      state <= LSC_SPI_IDLE;
      endcase
    end
  end

  assign miso      = tx_sr[FRAME_BITS-1];
  assign miso_oe_b = (state != LSC_SPI_SHIFT);
  assign rx_done   = (state == LSC_SPI_DONE);
  assign rx_len_ok = (cnt == `LSC_CNT_W'(FRAME_BITS));
endmodule // lsc_spi_shift

// File: tb/lsc_spi_host.sv
// lsc_spi_host: behavioural serial host issuing 16-bit mode 0 frames
module lsc_spi_host (
  // clock
  input  wire logic clk_sys,
  // serial pins
  output logic      sclk,
  output logic      cs_b,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // frame engine
  // ****************************************************************
  // idle: clock parked low, select high
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    mosi = 1'b0;
  end
  // high half periods of five clocks and low of ten leave margin for the three-flop sync
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge clk_sys);
    cs_b <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (5) @(posedge clk_sys);
      mosi <= tx[i];
      repeat (5) @(posedge clk_sys);
      sclk <= 1'b1;
      rx[i] = miso;
      repeat (5) @(posedge clk_sys);
      sclk <= 1'b0;
    end
    repeat (5) @(posedge clk_sys);
    cs_b <= 1'b1;
    mosi <= ~mosi; // released line must not look held
    repeat (16) @(posedge clk_sys);
  endtask
endmodule // lsc_spi_host

// File: tb/tb_top.sv
// tb_top: self-checking bench for the ch3/ch4 message block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lsc_pkg::*;
  // ****************************************************************
  // signals and cases
  // ****************************************************************
  typedef struct packed {
    logic [1:0] ctl;
    logic [4:0] id;
    logic [9:0] pay;
    logic [9:0] exp;
  } lsc_row_t;
  lsc_row_t rows [7] = '{'{2'h0, 5'h0c, 10'h3ff, 10'h3ff},
    '{2'h0, 5'h0d, 10'h001, 10'h001}, '{2'h2, 5'h0c, 10'h155, 10'h168},
    '{2'h1, 5'h0d, 10'h2ab, 10'h2a8}, '{2'h3, 5'h0c, 10'h0f0, 10'h123},
    '{2'h3, 5'h0d, 10'h0ff, 10'h2cc}, '{2'h2, 5'h0d, 10'h000, 10'h294}};
  logic clk_sys, rst_b, sclk, cs_b, mosi, miso, oe_b, pin, irq, dis, fb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr, d3, d4;
  logic [7:0]  rd3 = 8'h5a, rd4 = 8'ha5;
  logic [9:0]  t3, t4, a3 = 10'h123, a4 = 10'h2cc;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rr;
  logic [15:0] rx;
  lsc_flags_t  f3, f4, fl;
  lsc_row_t    r;
  int          n_fail = 0, n_compared = 0;
  assign pin = oe_b ? 1'b1 : miso; // pulled up while not driven
  lsc_ch34_msg dut (.clk_sys(clk_sys), .rst_b(rst_b), .spi_sclk(sclk),
    .spi_cs_b(cs_b), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe_b(oe_b),
    .ch3_flags(f3), .ch4_flags(f4), .ch3_regulator_duty(rd3),
    .ch4_regulator_duty(rd4), .ch3_adc_current(a3), .ch4_adc_current(a4),
    .regulation_disable_ch34(dis), .regulation_feedback_select(fb),
    .ch3_current_target(t3), .ch4_current_target(t4), .ch3_pwm_duty(d3),
    .ch4_pwm_duty(d4), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq));
  lsc_spi_host host (.clk_sys(clk_sys), .sclk(sclk), .cs_b(cs_b),
    .mosi(mosi), .miso(pin));
  // ****************************************************************
  // helpers
  // ****************************************************************
  // handshakes are judged at the rising edge; each channel drops once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      rd = rdata;
      rr = rresp;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  function automatic logic [15:0] fr(input logic [4:0] id,
                                     input logic [9:0] p);
    return {~^{id, p}, id, p};
  endfunction
  task automatic end_of_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************************************
  // clock, watchdog, tests
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // a hung handshake ends here; the run needs about 4300 clocks
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, f3, f4} = '0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk(oe_b === 1'b1 && irq === 1'b0, "reset outputs");
    axr(8'h00);
    chk(rd === 32'h0000_0000 && rr === 2'h0, "ctrl reset");
    axr(8'h1c);
    chk(rd === 32'h0000_0000 && rr === 2'h2, "unmapped read");
    foreach (rows[i]) begin
      r = rows[i];
      axw(8'h00, {30'h0, r.ctl});
      chk(bresp === 2'h0 && {fb, dis} === r.ctl, "mode write");
      f3 <= 4'(i);
      f4 <= 4'(~i);
      host.xfer(fr(r.id, r.pay), rx);
      fl = (r.id == 5'h0c) ? f3 : f4;
      host.xfer(fr(5'h1f, 10'h000), rx);
      chk(rx[14:0] === {1'b0, fl, r.exp}, "reply");
      chk(^rx === 1'b1, "reply parity");
      if (r.ctl[0]) chk((r.id == 5'h0c ? d3 : d4) === r.pay[9:2], "duty");
      else chk((r.id == 5'h0c ? t3 : t4) === r.pay, "target");
    end
    // bad parity: nothing stored, flag raised, interrupt path exercised
    axw(8'h10, 32'h0000_0007);
    axw(8'h14, 32'h0000_0002);
    chk(irq === 1'b0, "irq masked");
    host.xfer(fr(5'h0c, 10'h000) ^ 16'h8000, rx);
    host.xfer(fr(5'h1f, 10'h000), rx);
    chk(rx[14:10] === 5'h10 && t3 === 10'h155, "bad parity");
    chk(irq === 1'b1, "irq set");
    axr(8'h0c);
    chk(rd[1] === 1'b1, "status");
    axw(8'h10, 32'h0000_0002);
    chk(irq === 1'b0, "irq cleared");
    end_of_test();
  end
endmodule // tb_top
